/* hw/clsc_cfg.svh */
// Purpose: Constants for the cache line state controller
// Assumes: 32-bit words, 16-byte lines, 128 sets of four ways
// Notes: Offsets are byte addresses on the register port
`ifndef CLSC_CFG_SVH
`define CLSC_CFG_SVH
`define CLSC_REG_CTRL   8'h00
`define CLSC_REG_RGN0   8'h04
`define CLSC_REG_RGN1   8'h08
`define CLSC_REG_STAT   8'h0C
`define CLSC_CTRL_RST   32'h0000_0000
`define CLSC_RGN_RST    32'h0000_0000
`define CLSC_CTRL_EN    0
`define CLSC_CTRL_DCM   2:1
`define CLSC_CTRL_KEEP  3
`define CLSC_CTRL_INVA  4
`define CLSC_RGN_BASE   31:24
`define CLSC_RGN_MASK   23:16
`define CLSC_RGN_EN     15
`define CLSC_RGN_CM     6:5
`define CLSC_CM_WT      2'h0
`define CLSC_CM_CB      2'h1
`define CLSC_CM_INH     2'h2
`define CLSC_LAST_BEAT  2'h3
`endif

/* hw/clsc_pkg.sv */
// Purpose: Types for the cache line state controller
// Assumes: Constants live in clsc_cfg.svh
// Notes: Requests travel as packed structs
package clsc_pkg;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_INV, OP_PUSH} clsc_op_t;
  typedef enum {S_IDLE, S_LOOK, S_FILL, S_WB, S_WT, S_DRD} clsc_state_t;
  typedef struct packed {
    clsc_op_t    op;
    logic [31:0] addr;
    logic [31:0] wdata;
  } clsc_cpu_req_t;
  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } clsc_mem_req_t;
endpackage : clsc_pkg

/* hw/clsc_ctrl.sv */
// Purpose: Four-way cache with per-line state and write policies
// Assumes: Core, memory and register port share one clock
// Notes: Whole-word writes only; line ops address set and way directly
`timescale 1ns/1ps
`default_nettype none
`include "clsc_cfg.svh"
module clsc_ctrl (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  output logic [31:0]                 reg_rdata,
  input  wire clsc_pkg::clsc_cpu_req_t cpu_req,
  input  wire logic                   cpu_valid,
  output logic                        cpu_ready,
  output logic                        cpu_done,
  output logic [31:0]                 cpu_rdata,
  output clsc_pkg::clsc_mem_req_t     mem_req,
  output logic                        mem_valid,
  input  wire logic                   mem_ack,
  input  wire logic [31:0]            mem_rdata
);
  import clsc_pkg::*;

  clsc_state_t   state;
  clsc_cpu_req_t req;
  logic [31:0]   ctrl;
  logic [31:0]   rgn [2];
  logic [20:0]   tag_mem [512];
  logic [31:0]   data_mem [2048];
  logic [511:0]  valid;
  logic [511:0]  mod;
  logic [31:0]   pb_data [4];
  logic [27:0]   pb_addr;
  logic          pb_pending;
  logic [1:0]    rr;
  logic [1:0]    way;
  logic [1:0]    beat;
  logic          last_hit;

  function automatic logic [1:0] low_way(input logic [3:0] v);
    logic [1:0] w;
    w = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) w = 2'(i);
    end
    return w;
  endfunction : low_way

  function automatic logic rgn_match(input logic [31:0] r,
                                     input logic [7:0] a);
    return r[`CLSC_RGN_EN] &&
      (((a ^ r[`CLSC_RGN_BASE]) & ~r[`CLSC_RGN_MASK]) == 8'h00);
  endfunction : rgn_match

  wire logic [6:0]  set_i = req.addr[10:4];
  wire logic [20:0] tag_i = req.addr[31:11];
  wire logic [1:0]  word_i = req.addr[3:2];
  wire logic        line_op = req.op == OP_INV || req.op == OP_PUSH;
  wire logic        st_look = state == S_LOOK;
  wire logic        keep = ctrl[`CLSC_CTRL_KEEP];

  logic [3:0] hit_vec;
  logic [3:0] inv_vec;
  for (genvar g = 0; g < 4; g++) begin : g_way
    assign hit_vec[g] = valid[{set_i, 2'(g)}] &&
                        tag_mem[{set_i, 2'(g)}] == tag_i;
    assign inv_vec[g] = !valid[{set_i, 2'(g)}];
  end

  // Disabled cache behaves as inhibited for reads and writes
  wire logic m0 = rgn_match(rgn[0], req.addr[31:24]);
  wire logic m1 = rgn_match(rgn[1], req.addr[31:24]);
  wire logic [1:0] policy = !ctrl[`CLSC_CTRL_EN] ? `CLSC_CM_INH :
                            m0 ? rgn[0][`CLSC_RGN_CM] :
                            m1 ? rgn[1][`CLSC_RGN_CM] :
                            ctrl[`CLSC_CTRL_DCM];
  wire logic cacheable = !policy[1];
  wire logic copyback  = policy == `CLSC_CM_CB;

  wire logic       hit = |hit_vec;
  wire logic [1:0] victim = |inv_vec ? low_way(inv_vec)
                                     : rr;
  wire logic [1:0] sel_way = line_op ? req.addr[1:0] :
                             hit ? low_way(hit_vec) : victim;
  wire logic [8:0] sel_idx = {set_i, sel_way};
  wire logic [8:0] cur_idx = {set_i, way};
  wire logic       sel_v = valid[sel_idx];
  wire logic       sel_m = mod[sel_idx];
  wire logic [1:0] nbeat = beat + 2'h1;

  wire logic is_rd = req.op == OP_READ;
  wire logic is_wr = req.op == OP_WRITE;
  wire logic look_rd_hit = st_look && is_rd && cacheable && hit;
  wire logic look_wr_hit = st_look && is_wr && cacheable && hit;
  wire logic fill_start  = st_look && !hit && cacheable &&
                           (is_rd || (is_wr && copyback));
  wire logic wt_miss     = st_look && is_wr && cacheable &&
                           !copyback && !hit;
  wire logic fill_ack    = state == S_FILL && mem_ack;
  wire logic fill_last   = fill_ack && beat == `CLSC_LAST_BEAT;
  wire logic wb_last     = state == S_WB && mem_ack &&
                           beat == `CLSC_LAST_BEAT;
  wire logic inva = reg_write && reg_addr == `CLSC_REG_CTRL &&
                    reg_wdata[`CLSC_CTRL_INVA];

  assign cpu_ready = state == S_IDLE;

  wire logic [31:0] stat_word = {29'h0000_0000, last_hit, pb_pending,
                                 state != S_IDLE};
  wire logic [31:0] reg_mux =
    reg_addr == `CLSC_REG_CTRL ? ctrl :
    reg_addr == `CLSC_REG_RGN0 ? rgn[0] :
    reg_addr == `CLSC_REG_RGN1 ? rgn[1] :
    reg_addr == `CLSC_REG_STAT ? stat_word : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl      <= `CLSC_CTRL_RST;
      rgn[0]    <= `CLSC_RGN_RST;
      rgn[1]    <= `CLSC_RGN_RST;
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_read ? reg_mux : 32'h0000_0000;
      if (reg_write && reg_addr == `CLSC_REG_CTRL)
        ctrl <= reg_wdata & ~(32'h0000_0001 << `CLSC_CTRL_INVA);
      if (reg_write && reg_addr == `CLSC_REG_RGN0) rgn[0] <= reg_wdata;
      if (reg_write && reg_addr == `CLSC_REG_RGN1) rgn[1] <= reg_wdata;
    end
  end

  // Arrays carry no reset: contents survive a reset
  always_ff @(posedge clock) begin
    if (fill_ack) data_mem[{cur_idx, beat}] <= mem_rdata;
    if (look_wr_hit) data_mem[{sel_idx, word_i}] <= req.wdata;
    if (fill_last && is_wr) data_mem[{cur_idx, word_i}] <= req.wdata;
    if (fill_last) tag_mem[cur_idx] <= tag_i;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state      <= S_IDLE;
      req        <= '0;
      valid      <= '0;
      mod        <= '0;
      pb_addr    <= 28'h000_0000;
      pb_pending <= 1'b0;
      rr         <= 2'h0;
      way        <= 2'h0;
      beat       <= 2'h0;
      last_hit   <= 1'b0;
      cpu_done   <= 1'b0;
      cpu_rdata  <= 32'h0000_0000;
      mem_req    <= '0;
      mem_valid  <= 1'b0;
    end else begin
      cpu_done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cpu_valid) begin
            req   <= cpu_req;
            state <= S_LOOK;
          end
        end
        S_LOOK: begin
          way   <= sel_way;
          state <= S_IDLE;
          if (!line_op) last_hit <= hit && cacheable;
          // Line ops skip this path so they work with the cache off
          if (!line_op && (!cacheable || wt_miss)) begin
            mem_req   <= '{we: is_wr, addr: req.addr, wdata: req.wdata};
            mem_valid <= 1'b1;
            state     <= is_wr ? S_WT : S_DRD;
          end else if (look_rd_hit) begin
            cpu_rdata <= data_mem[{sel_idx, word_i}];
            cpu_done  <= 1'b1;
          end else if (look_wr_hit && copyback) begin
            mod[sel_idx] <= 1'b1;
            cpu_done     <= 1'b1;
          end else if (look_wr_hit) begin
            mod[sel_idx] <= 1'b0;
            mem_req   <= '{we: 1'b1, addr: req.addr, wdata: req.wdata};
            mem_valid <= 1'b1;
            state     <= S_WT;
          end else if (fill_start) begin
            // Victim leaves the set now so a half-filled line never hits
            valid[sel_idx] <= 1'b0;
            mod[sel_idx]   <= 1'b0;
            if (inv_vec == 4'h0) rr <= rr + 2'h1;
            if (sel_v && sel_m) begin
              for (int i = 0; i < 4; i++)
                pb_data[i] <= data_mem[{sel_idx, 2'(i)}];
              pb_addr    <= {tag_mem[sel_idx], set_i};
              pb_pending <= 1'b1;
            end
            mem_req   <= '{we: 1'b0, addr: {req.addr[31:4], 4'h0},
                           wdata: 32'h0000_0000};
            mem_valid <= 1'b1;
            beat      <= 2'h0;
            state     <= S_FILL;
          end else if (req.op == OP_PUSH && sel_m) begin
            for (int i = 0; i < 4; i++)
              pb_data[i] <= data_mem[{sel_idx, 2'(i)}];
            pb_addr    <= {tag_mem[sel_idx], set_i};
            pb_pending <= 1'b1;
            mem_req    <= '{we: 1'b1,
                            addr: {tag_mem[sel_idx], set_i, 4'h0},
                            wdata: data_mem[{sel_idx, 2'h0}]};
            mem_valid  <= 1'b1;
            beat       <= 2'h0;
            state      <= S_WB;
          end else begin
            // Invalidate, or push of a clean or empty line: no traffic
            if (req.op == OP_INV || !keep) begin
              valid[sel_idx] <= 1'b0;
              mod[sel_idx]   <= 1'b0;
            end
            cpu_done <= 1'b1;
          end
        end
        S_FILL: begin
          if (fill_ack) begin
            if (beat == word_i) cpu_rdata <= mem_rdata;
            beat         <= nbeat;
            mem_req.addr <= {req.addr[31:4], nbeat, 2'h0};
            if (fill_last) begin
              valid[cur_idx] <= 1'b1;
              mod[cur_idx]   <= is_wr;
              if (pb_pending) begin
                mem_req <= '{we: 1'b1, addr: {pb_addr, 4'h0},
                             wdata: pb_data[0]};
                state   <= S_WB;
              end else begin
                mem_valid <= 1'b0;
                cpu_done  <= 1'b1;
                state     <= S_IDLE;
              end
            end
          end
        end
        S_WB: begin
          if (mem_ack) begin
            beat          <= nbeat;
            mem_req.addr  <= {pb_addr, nbeat, 2'h0};
            mem_req.wdata <= pb_data[nbeat];
            if (wb_last) begin
              pb_pending <= 1'b0;
              mem_valid  <= 1'b0;
              cpu_done   <= 1'b1;
              state      <= S_IDLE;
              if (req.op == OP_PUSH) begin
                valid[cur_idx] <= keep;
                mod[cur_idx]   <= 1'b0;
              end
            end
          end
        end
        S_WT, S_DRD: begin
          if (mem_ack) begin
            if (state == S_DRD) cpu_rdata <= mem_rdata;
            mem_valid <= 1'b0;
            cpu_done  <= 1'b1;
            state     <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
      // Software flush wins over any line update in the same cycle
      if (inva) begin
        valid <= '0;
        mod   <= '0;
      end
    end
  end

  default clocking cb_main @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_fill_dirty_end;
    fill_last && pb_pending;
  endsequence
  sequence s_wb_begin;
    state == S_WB && mem_valid && mem_req.we;
  endsequence

  a_line_encoding: assert property ((mod & ~valid) == '0)
    else $error("modified bit set on an invalid line");
  a_policy_region: assert property (
    st_look && m0 && ctrl[`CLSC_CTRL_EN] |-> policy == rgn[0][`CLSC_RGN_CM])
    else $error("region policy not applied");
  a_miss_fills: assert property (
    st_look && is_rd && cacheable && !hit && !inva
      |=> state == S_FILL && mem_valid && !mem_req.we)
    else $error("read miss did not start a line fill");
  a_invalid_first: assert property (
    fill_start && inv_vec != 4'h0 |-> !sel_v)
    else $error("valid line replaced while an invalid way existed");
  a_fill_valid: assert property (fill_last && !inva |=> valid[cur_idx])
    else $error("filled line not marked valid");
  a_victim_rr: assert property (
    fill_start && inv_vec == 4'h0
      |-> sel_way == rr ##1 rr == $past(rr) + 2'h1)
    else $error("victim not taken from round-robin pointer");
  a_push_order: assert property (
    state == S_FILL
      |-> (!mem_req.we and (s_fill_dirty_end |=> s_wb_begin)))
    else $error("dirty victim not written after the fill");
  a_read_hit_fast: assert property (
    look_rd_hit && !inva |=> cpu_done && !mem_valid && valid[cur_idx] &&
                             mod[cur_idx] == $past(sel_m))
    else $error("read hit touched memory or changed line state");
  a_cb_hit_dirty: assert property (
    look_wr_hit && copyback && !inva |=> mod[cur_idx] && !mem_valid)
    else $error("copyback write hit did not mark line modified");
  a_wt_hit_clean: assert property (
    look_wr_hit && !copyback && !inva
      |=> valid[cur_idx] && !mod[cur_idx] && mem_valid && mem_req.we)
    else $error("write-through hit did not write memory and clean line");
  a_wt_miss_none: assert property (
    wt_miss && !inva |=> state == S_WT && $stable(valid) && $stable(mod))
    else $error("write-through miss allocated or changed a line");
  a_inv_drop: assert property (
    st_look && req.op == OP_INV |=> !valid[cur_idx] && !mem_valid)
    else $error("invalidate left line valid or made traffic");
  a_push_result: assert property (
    wb_last && req.op == OP_PUSH && !inva
      |=> valid[cur_idx] == keep && !mod[cur_idx])
    else $error("push left wrong line state");
endmodule : clsc_ctrl
`default_nettype wire

/* bench/clsc_mem_model.sv */
// Purpose: Word memory behind the cache, answering each request once
// Assumes: One clock; request held by the cache until acknowledged
// Notes: Delay input stretches every answer to test slow memory
`timescale 1ns/1ps
`default_nettype none
module clsc_mem_model (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire clsc_pkg::clsc_mem_req_t mem_req,
  input  wire logic                    mem_valid,
  input  wire logic [1:0]              delay,
  output logic                         mem_ack,
  output logic [31:0]                  mem_rdata
);
  import clsc_pkg::*;
  logic [31:0] store [logic [31:0]];
  logic [7:0]  hist;
  logic [31:0] last_wr;
  logic [1:0]  wait_cnt;
  int          n_rd;
  int          n_wr;
  function automatic logic [31:0] fetch(input logic [31:0] a);
    return store.exists(a) ? store[a] : (a ^ 32'h5A5A_0000);
  endfunction : fetch
  always @(posedge clock) begin
    if (reset) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      wait_cnt  <= 2'h0;
    end else if (mem_ack && mem_valid) begin
      // Word taken here; data toggles after so stale reads show up
      mem_ack   <= 1'b0;
      wait_cnt  <= 2'h0;
      mem_rdata <= ~mem_rdata;
      hist      = {hist[6:0], mem_req.we};
      if (mem_req.we) begin
        store[mem_req.addr] = mem_req.wdata;
        last_wr = mem_req.addr;
        n_wr++;
      end else begin
        n_rd++;
      end
    end else if (mem_valid && wait_cnt == delay) begin
      mem_ack   <= 1'b1;
      mem_rdata <= fetch(mem_req.addr);
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_valid) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule : clsc_mem_model
`default_nettype wire

/* bench/testbench.sv */
// Purpose: Self-checking bench for the cache line state controller
// Assumes: Memory model counts every acknowledged word
// Notes: Line ops sweep all four ways; a mask names the dirty ways
`timescale 1ns/1ps
`default_nettype none
`include "clsc_cfg.svh"
module testbench;
  import clsc_pkg::*;
  logic          clock;
  logic          reset;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata;
  logic          reg_write;
  logic          reg_read;
  logic [31:0]   reg_rdata;
  clsc_cpu_req_t cpu_req;
  logic          cpu_valid;
  logic          cpu_ready;
  logic          cpu_done;
  logic [31:0]   cpu_rdata;
  clsc_mem_req_t mem_req;
  logic          mem_valid;
  logic          mem_ack;
  logic [31:0]   mem_rdata;
  logic [1:0]    mem_delay;
  logic [31:0]   rd;
  logic [31:0]   v1;
  int            fail_count;
  int            n_compared;
  int            cycles;
  int            lat;
  int            dr;
  int            dw;
  clsc_ctrl dut_u (.clock, .reset, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .cpu_req, .cpu_valid, .cpu_ready, .cpu_done,
    .cpu_rdata, .mem_req, .mem_valid, .mem_ack, .mem_rdata);
  clsc_mem_model mem_u (.clock, .reset, .mem_req, .mem_valid,
    .delay(mem_delay), .mem_ack, .mem_rdata);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] la(input int t, input int s);
    return {t[20:0], s[6:0], 4'h0};
  endfunction : la
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_rd
  task automatic cpu_op(input clsc_op_t op, input logic [31:0] a,
                        input logic [31:0] d);
    int r0;
    int w0;
    r0 = mem_u.n_rd;
    w0 = mem_u.n_wr;
    @(posedge clock);
    cpu_req   <= '{op: op, addr: a, wdata: d};
    cpu_valid <= 1'b1;
    @(posedge clock);
    cpu_valid <= 1'b0;
    #1 chk(32'(cpu_ready), 32'h0000_0000);
    lat = 0;
    do begin
      @(posedge clock);
      #1 lat++;
    end while (cpu_done !== 1'b1 && lat < 300);
    if (lat >= 300) fail_count++;
    chk(32'(cpu_ready), 32'h0000_0001);
    rd = cpu_rdata;
    dr = mem_u.n_rd - r0;
    dw = mem_u.n_wr - w0;
  endtask : cpu_op
  task automatic op_chk(input clsc_op_t op, input logic [31:0] a,
                        input logic [31:0] d, input int r, input int w);
    cpu_op(op, a, d);
    chk(32'(dr), 32'(r));
    chk(32'(dw), 32'(w));
  endtask : op_chk
  // Line op on every way of a set; a dirty way writes back a whole line
  task automatic sweep(input clsc_op_t op, input int s,
                       input logic [3:0] m, input int w);
    int w0;
    w0 = mem_u.n_wr;
    for (int k = 0; k < 4; k++) begin
      op_chk(op, {21'h0, s[6:0], 2'b00, k[1:0]}, 32'h0, 0, m[k] ? 4 : 0);
    end
    chk(32'(mem_u.n_wr - w0), 32'(w));
  endtask : sweep
  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    cpu_req = '0;
    cpu_valid = 1'b0;
    mem_delay = 2'h0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    reg_rd(`CLSC_REG_CTRL);
    chk(rd, `CLSC_CTRL_RST);
    reg_wr(`CLSC_REG_CTRL, 32'h0000_0013);
    reg_rd(`CLSC_REG_CTRL);
    chk(rd, 32'h0000_0003);
    reg_rd(8'h10);
    chk(rd, 32'h0000_0000);
    op_chk(OP_READ, la(1, 5), 0, 4, 0);
    chk(rd, la(1, 5) ^ 32'h5A5A_0000);
    op_chk(OP_READ, la(1, 5) + 4, 0, 0, 0);
    chk(rd, (la(1, 5) + 4) ^ 32'h5A5A_0000);
    chk(32'(lat), 32'h0000_0001);
    reg_rd(`CLSC_REG_STAT);
    chk(rd, 32'h0000_0004);
    op_chk(OP_WRITE, la(1, 5), 32'h1111_0000, 0, 0);
    op_chk(OP_READ, la(1, 5), 0, 0, 0);
    chk(rd, 32'h1111_0000);
    for (int t = 2; t < 5; t++) op_chk(OP_READ, la(t, 5), 0, 4, 0);
    for (int t = 1; t < 5; t++) begin
      op_chk(OP_WRITE, la(t, 5), 32'hD000_0000 | t, 0, 0);
    end
    // Slow memory while whole set is dirty
    mem_delay <= 2'h2;
    op_chk(OP_READ, la(5, 5), 0, 4, 4);
    chk(rd, la(5, 5) ^ 32'h5A5A_0000);
    chk({24'h0, mem_u.hist}, 32'h0000_000F);
    v1 = mem_u.last_wr & 32'hFFFF_FFF0;
    chk(mem_u.fetch(v1), 32'hD000_0000 | (v1 >> 11));
    op_chk(OP_READ, la(6, 5), 0, 4, 4);
    chk(32'((mem_u.last_wr & 32'hFFFF_FFF0) != v1), 32'd1);
    mem_delay <= 2'h0;
    op_chk(OP_READ, la(1, 9), 0, 4, 0);
    op_chk(OP_WRITE, la(1, 9), 32'h9999_0001, 0, 0);
    reg_wr(`CLSC_REG_CTRL, 32'h0000_000B);
    sweep(OP_PUSH, 5, 4'hC, 8);
    sweep(OP_PUSH, 5, 4'h0, 0);
    op_chk(OP_READ, la(5, 5), 0, 0, 0);
    reg_wr(`CLSC_REG_CTRL, 32'h0000_0003);
    sweep(OP_PUSH, 5, 4'h0, 0);
    op_chk(OP_READ, la(5, 5), 0, 4, 0);
    op_chk(OP_WRITE, la(5, 5), 32'hEEEE_0005, 0, 0);
    sweep(OP_PUSH, 5, 4'h1, 4);
    chk(mem_u.fetch(la(5, 5)), 32'hEEEE_0005);
    op_chk(OP_READ, la(5, 5), 0, 4, 0);
    op_chk(OP_WRITE, la(5, 5), 32'hFFFF_0005, 0, 0);
    sweep(OP_INV, 5, 4'h0, 0);
    op_chk(OP_READ, la(5, 5), 0, 4, 0);
    chk(rd, 32'hEEEE_0005);
    // Set 5 flushed before the switch, set 9 left dirty on purpose
    reg_wr(`CLSC_REG_CTRL, 32'h0000_0001);
    op_chk(OP_WRITE, la(2, 9), 32'h2222_0009, 0, 1);
    chk(mem_u.fetch(la(2, 9)), 32'h2222_0009);
    op_chk(OP_READ, la(1, 9), 0, 0, 0);
    chk(rd, 32'h9999_0001);
    op_chk(OP_READ, la(2, 9), 0, 4, 0);
    op_chk(OP_WRITE, la(1, 9), 32'h9999_0002, 0, 1);
    sweep(OP_PUSH, 9, 4'h0, 0);
    op_chk(OP_READ, la(3, 9), 0, 4, 0);
    op_chk(OP_WRITE, la(3, 9), 32'h3333_0009, 0, 1);
    op_chk(OP_READ, la(3, 9), 0, 0, 0);
    chk(rd, 32'h3333_0009);
    sweep(OP_PUSH, 9, 4'h0, 0);
    reg_wr(`CLSC_REG_RGN0, 32'h1000_8000);
    reg_wr(`CLSC_REG_RGN1, 32'h2000_8040);
    reg_wr(`CLSC_REG_CTRL, 32'h0000_0003);
    reg_rd(`CLSC_REG_RGN0);
    chk(rd, 32'h1000_8000);
    op_chk(OP_READ, 32'h1000_0A00, 0, 4, 0);
    op_chk(OP_WRITE, 32'h1000_0A00, 32'h4444_0000, 0, 1);
    op_chk(OP_READ, 32'h2000_0B00, 0, 1, 0);
    chk(rd, 32'h2000_0B00 ^ 32'h5A5A_0000);
    op_chk(OP_READ, 32'h2000_0B00, 0, 1, 0);
    // Cache off: pushes on the empty set 9 stay quiet, accesses go straight to memory
    reg_wr(`CLSC_REG_CTRL, 32'h0000_0000);
    sweep(OP_PUSH, 9, 4'h0, 0);
    op_chk(OP_READ, la(3, 9), 0, 1, 0);
    chk(rd, 32'h3333_0009);
    test_done();
  end
endmodule : testbench
`default_nettype wire
